// ---- logic/stl_ctrl.sv ----
`timescale 1ns/10ps
`include "stl_params.svh"

// How it works
// - Coil enable bit drives full-step coil control
// - Power bit switches the converter on/off
// - Wait-disable clear keeps block running in wait
// - Wait-disable set freezes divider, powers converter down
// - Frozen wait with coil enable recirculates coils
// - Factory test bit reads zero, no function
// - Sample rate is bus over 8*2^select
// - New select applies only after integrate clears
// - Underflow flag sets when count reaches zero
// - Underflow flag and enable raise interrupt
// - Overflow flag sets on either accumulator overflow
// - Overflow flag and enable raise interrupt
// - Write one clears flag; zero leaves it
// - Both registers accessible at any time
// - Integrate low holds accumulator zero, converter reset
// - Accumulator saturates at positive or negative limit
// - Writing zero count sets no underflow
// - Underflow enable gates the underflow interrupt

module stl_ctrl #(
    parameter int ACC_W = `STL_ACC_WIDTH,
    parameter int CNT_W = `STL_CNT_WIDTH,
    parameter int SEL_W = `STL_SEL_WIDTH
) (
    // Clock and reset
    input  wire logic             hclk,
    input  wire logic             hresetn,
    // AHB-Lite slave
    input  wire logic             hsel,
    input  wire logic [31:0]      haddr,
    input  wire logic [1:0]       htrans,
    input  wire logic             hwrite,
    input  wire logic [2:0]       hsize,
    input  wire logic [31:0]      hwdata,
    input  wire logic             hready,
    output logic      [31:0]      hrdata,
    output logic                  hreadyout,
    output logic                  hresp,
    // System and neighbouring blocks
    input  wire logic             wait_mode,
    input  wire logic             integrate_mode,
    input  wire logic             underflow_irq_enable,
    input  wire logic             accum_overflow_irq_enable,
    input  wire logic             count_step,
    input  wire logic [CNT_W-1:0] modulus_count,
    // Converter output pin
    input  wire logic             converter_sample,
    // Coil and converter control
    output logic                  coil_control_enable,
    output logic                  coil_recirculate,
    output logic                  converter_power_up,
    output logic                  converter_reset,
    output logic                  prescaler_run,
    // Accumulator and sample rate
    output logic                  sample_tick,
    output logic      [ACC_W-1:0] accumulator,
    // Interrupt requests
    output logic                  underflow_irq,
    output logic                  accum_overflow_irq
);

    // Refuse widths the logic cannot serve
    if (ACC_W < 2 || CNT_W < 1 || SEL_W != `STL_SEL_WIDTH) begin : g_bad
        $error("stl_ctrl: unsupported ACC_W, CNT_W or SEL_W");
    end

    // Bus decode

    stl_pkg::stl_ctrl_s   ctrl;       // Stored control fields
    stl_pkg::stl_aphase_s aph;        // Pending write data phase
    logic                 flag_under; // Underflow sticky flag
    logic                 flag_over;  // Overflow sticky flag

    wire       addr_ok;   // Upper address bits zero
    wire       take;      // Transfer accepted this edge
    wire [3:0] idx;       // Word index of address phase
    wire       rd_take;   // Read accepted
    wire       wr_ctrl;   // Control write data phase
    wire       wr_flag;   // Flag write data phase

    // Accepted when selected, active, ready, a whole word and upper address bits zero
    assign addr_ok = haddr[31:`STL_ADDR_HI_LSB] == `STL_ADDR_HI_ZERO;
    assign take    = hsel && htrans[`STL_HTRANS_ACT_BIT] && hready
                     && hsize == `STL_HSIZE_WORD && addr_ok;
    assign idx     = haddr[`STL_IDX_MSB:`STL_IDX_LSB];
    assign rd_take = take && !hwrite;
    assign wr_ctrl = aph.wr && aph.idx == `STL_IDX_CTRL;
    assign wr_flag = aph.wr && aph.idx == `STL_IDX_FLAG;

    // Address phase capture for the write data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            aph <= '0;
        end else begin
            aph.wr  <= take && hwrite;
            aph.idx <= idx;
        end
    end

    // Read data

    wire [7:0]  ctrl_view;   // Control byte as read
    wire [7:0]  flag_view;   // Flag byte as read
    wire [31:0] next_rdata;  // Read word for the data phase

    // Test bit and bits 3:2 read zero
    assign ctrl_view = {ctrl.coil_en, ctrl.pwr_up, ctrl.wait_dis,
                        1'b0, 2'b00,
                        ctrl.sample_rate_select};
    // Bits 6:1 read zero
    assign flag_view = {flag_under, 6'h00, flag_over};

    // Unmapped addresses read zero
    assign next_rdata =
        !rd_take                 ? `STL_RDATA_RESET :
        idx == `STL_IDX_CTRL     ? {24'h000000, ctrl_view} :
        idx == `STL_IDX_FLAG     ? {24'h000000, flag_view} :
                                   `STL_RDATA_RESET;

    // Registered read word, valid in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= `STL_RDATA_RESET;
        end else begin
            hrdata <= next_rdata;
        end
    end

    // Zero wait state, always OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp     <= `STL_HRESP_OKAY;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= `STL_HRESP_OKAY;
        end
    end

    // Control register

    // Writable fields; test bit and bits 3:2 are dropped
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl.coil_en            <= `STL_CTRL_RESET;
            ctrl.pwr_up             <= `STL_CTRL_RESET;
            ctrl.wait_dis           <= `STL_CTRL_RESET;
            ctrl.sample_rate_select <= `STL_SEL_RESET;
        end else if (wr_ctrl) begin
            ctrl.coil_en  <= hwdata[`STL_CTRL_COIL_EN];
            ctrl.pwr_up   <= hwdata[`STL_CTRL_PWR_UP];
            ctrl.wait_dis <= hwdata[`STL_CTRL_WAIT_DIS];
            ctrl.sample_rate_select <=
                hwdata[`STL_CTRL_SEL_MSB:`STL_CTRL_SEL_LSB];
        end
    end

    // Power, wait and coil control

    wire freeze;      // Wait entered with freezing allowed

    // Only a set wait-disable bit freezes in wait
    assign freeze = ctrl.wait_dis && wait_mode;

    // Registered control outputs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            coil_control_enable <= 1'b0;
            coil_recirculate    <= 1'b0;
            converter_power_up  <= 1'b0;
            converter_reset     <= 1'b1;
            prescaler_run       <= 1'b0;
        end else begin
            coil_control_enable <= ctrl.coil_en;
            coil_recirculate    <= freeze && ctrl.coil_en;
            converter_power_up  <= ctrl.pwr_up && !freeze;
            converter_reset     <= !integrate_mode;
            prescaler_run       <= !freeze;
        end
    end

    // Sample rate

    logic [SEL_W-1:0] sel_eff;   // Select in force for the divider

    // New select passes only while integrate is low
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sel_eff <= `STL_SEL_RESET;
        end else if (!integrate_mode) begin
            sel_eff <= ctrl.sample_rate_select;
        end
    end

    // Divider of the bus clock
    stl_rate_div #(
        .SEL_W     (SEL_W),
        .BASE_LOG2 (`STL_DIV_BASE_LOG2)
    ) u_div (
        .hclk    (hclk),
        .hresetn (hresetn),
        .sel     (sel_eff),
        .freeze  (freeze),
        .tick    (sample_tick)
    );

    // Accumulator

    logic sample_meta;   // Pin synchroniser, first stage
    logic sample_bit;    // Pin synchroniser, second stage

    // Two stage synchroniser of the converter pin
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sample_meta <= 1'b0;
            sample_bit  <= 1'b0;
        end else begin
            sample_meta <= converter_sample;
            sample_bit  <= sample_meta;
        end
    end

    wire [ACC_W-1:0] acc_max = {1'b0, {(ACC_W-1){1'b1}}};
    wire [ACC_W-1:0] acc_min = {1'b1, {(ACC_W-1){1'b0}}};
    wire [ACC_W-1:0] acc_one = {{(ACC_W-1){1'b0}}, 1'b1};
    wire             pos_ovf;   // Step up past the top
    wire             neg_ovf;   // Step down past the bottom
    wire             ovf_event; // Either overflow this cycle

    // Overflow is a step attempted at a limit
    assign pos_ovf   = integrate_mode && sample_tick && sample_bit
                       && accumulator == acc_max;
    assign neg_ovf   = integrate_mode && sample_tick && !sample_bit
                       && accumulator == acc_min;
    assign ovf_event = pos_ovf || neg_ovf;

    // Cleared while idle, saturating while integrating
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            accumulator <= '0;
        end else if (!integrate_mode) begin
            accumulator <= '0;
        end else if (sample_tick && !ovf_event) begin
            accumulator <= sample_bit ? accumulator + acc_one
                                      : accumulator - acc_one;
        end
    end

    // Flags and interrupts

    wire under_event; // Counter steps from one to zero
    wire clr_under;   // Software clears underflow flag
    wire clr_over;    // Software clears overflow flag

    // A loaded zero is never a step, so it raises nothing
    assign under_event = count_step
        && modulus_count == CNT_W'(`STL_COUNT_LAST);
    assign clr_under   = wr_flag && hwdata[`STL_FLAG_UNDER];
    assign clr_over    = wr_flag && hwdata[`STL_FLAG_OVER];

    // Underflow sticky flag
    stl_flag u_under (
        .hclk    (hclk),
        .hresetn (hresetn),
        .set     (under_event),
        .clr     (clr_under),
        .q       (flag_under)
    );

    // Overflow sticky flag
    stl_flag u_over (
        .hclk    (hclk),
        .hresetn (hresetn),
        .set     (ovf_event),
        .clr     (clr_over),
        .q       (flag_over)
    );

    // Requests stay pending while flag and enable are set
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            underflow_irq      <= 1'b0;
            accum_overflow_irq <= 1'b0;
        end else begin
            underflow_irq      <= flag_under
                                  && underflow_irq_enable;
            accum_overflow_irq <= flag_over
                                  && accum_overflow_irq_enable;
        end
    end

    // Checks

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // Control write data phase carrying a coil enable value
    sequence s_coil_write(logic v);
        wr_ctrl && hwdata[`STL_CTRL_COIL_EN] == v;
    endsequence

    AST_COIL_ENABLE: assert property (
        s_coil_write(1'b1) ##1 !wr_ctrl |=> coil_control_enable)
        else $error("coil enable did not follow write");

    AST_COIL_DISABLE: assert property (
        s_coil_write(1'b0) ##1 !wr_ctrl |=> !coil_control_enable)
        else $error("coil enable did not clear");

    AST_PWR_FOLLOW: assert property (
        converter_power_up == $past(ctrl.pwr_up && !freeze))
        else $error("converter power wrong");

    AST_WAIT_RUNS: assert property (
        !ctrl.wait_dis && wait_mode |=> prescaler_run)
        else $error("block stopped in wait with freezing off");

    AST_WAIT_FREEZE: assert property (
        freeze |=> !prescaler_run && !converter_power_up)
        else $error("wait did not freeze");

    AST_RECIRC: assert property (
        freeze && ctrl.coil_en |=> coil_recirculate)
        else $error("coils not recirculated in wait");

    AST_READ_ZERO: assert property (
        hrdata[`STL_CTRL_TEST:2] == 3'b000)
        else $error("reserved control bits read non zero");

    AST_SEL_HELD: assert property (
        integrate_mode |=> $stable(sel_eff))
        else $error("select changed while integrating");

    AST_UNDER_IRQ: assert property (
        under_event ##1 underflow_irq_enable |=> underflow_irq)
        else $error("underflow did not raise request");

    AST_OVER_IRQ: assert property (
        accum_overflow_irq == $past(flag_over
                                    && accum_overflow_irq_enable))
        else $error("overflow request wrong");

    AST_SAT_HIGH: assert property (
        pos_ovf |=> accumulator == acc_max && flag_over)
        else $error("positive saturation lost");

    AST_SAT_LOW: assert property (
        neg_ovf |=> accumulator == acc_min && flag_over)
        else $error("negative saturation lost");

    AST_IDLE_ZERO: assert property (
        !integrate_mode |=> accumulator == '0 && converter_reset)
        else $error("accumulator not held at zero");

endmodule

// ---- logic/stl_params.svh ----
`ifndef STL_PARAMS_SVH
`define STL_PARAMS_SVH

// Register indices; byte address is four times the index
`define STL_IDX_CTRL       4'h2
`define STL_IDX_FLAG       4'h3
`define STL_IDX_MSB        5
`define STL_IDX_LSB        2
`define STL_ADDR_HI_ZERO   26'h0
`define STL_ADDR_HI_LSB    6

// Control register bit positions
`define STL_CTRL_COIL_EN   7
`define STL_CTRL_PWR_UP    6
`define STL_CTRL_WAIT_DIS  5
`define STL_CTRL_TEST      4
`define STL_CTRL_SEL_MSB   1
`define STL_CTRL_SEL_LSB   0

// Flag register bit positions
`define STL_FLAG_UNDER     7
`define STL_FLAG_OVER      0

// Reset values
`define STL_CTRL_RESET     1'b0
`define STL_SEL_RESET      2'h0
`define STL_RDATA_RESET    32'h0000_0000

// AHB-Lite encodings
`define STL_HSIZE_WORD     3'h2
`define STL_HTRANS_ACT_BIT 1
`define STL_HRESP_OKAY     1'b0

// Sample divider: bus clock over 8 times two to the select
`define STL_DIV_BASE_LOG2  3
`define STL_SEL_WIDTH      2

// Datapath widths and modulus count value just before zero
`define STL_ACC_WIDTH      16
`define STL_CNT_WIDTH      16
`define STL_COUNT_LAST     16'h0001

`endif

// ---- logic/stl_pkg.sv ----
package stl_pkg;

    // Stored control fields
    typedef struct packed {
        logic       coil_en;            // Return to zero coil drive
        logic       pwr_up;             // Converter power up
        logic       wait_dis;           // Freeze in wait mode
        logic [1:0] sample_rate_select; // Sample rate divider select
    } stl_ctrl_s;

    // Captured AHB address phase
    typedef struct packed {
        logic       wr;                 // Write data phase pending
        logic [3:0] idx;                // Word index of the access
    } stl_aphase_s;

endpackage

// ---- logic/stl_flag.sv ----
`timescale 1ns/10ps
`include "stl_params.svh"

module stl_flag (
    // Clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    // Hardware event and software clear
    input  wire logic set,
    input  wire logic clr,
    // Sticky flag
    output logic      q
);

    // Sticky bit; a set in the clearing cycle wins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= `STL_CTRL_RESET;
        end else if (set) begin
            q <= 1'b1;
        end else if (clr) begin
            q <= 1'b0;
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    AST_FLAG_SET_WINS: assert property (
        set |=> q) else $error("flag lost a set during clear");

    AST_FLAG_CLEAR: assert property (
        clr && !set |=> !q) else $error("flag did not clear on write one");

    AST_FLAG_HOLD: assert property (
        !clr && !set |=> q == $past(q)) else $error("flag changed by itself");

endmodule

// ---- logic/stl_rate_div.sv ----
`timescale 1ns/10ps
`include "stl_params.svh"

module stl_rate_div #(
    parameter int SEL_W     = `STL_SEL_WIDTH,
    parameter int BASE_LOG2 = `STL_DIV_BASE_LOG2
) (
    // Clock and reset
    input  wire logic             hclk,
    input  wire logic             hresetn,
    // Control
    input  wire logic [SEL_W-1:0] sel,
    input  wire logic             freeze,
    // One cycle pulse per sample period
    output logic                  tick
);

    localparam int CNT_W = BASE_LOG2 + (1 << SEL_W) - 1;

    // Refuse shapes the counter cannot serve
    if (SEL_W < 1 || SEL_W > 3 || BASE_LOG2 < 1) begin : g_bad_param
        $error("stl_rate_div: unsupported SEL_W or BASE_LOG2");
    end

    logic [CNT_W-1:0] cnt;       // Bus clock count in period
    wire  [CNT_W-1:0] one = {{(CNT_W-1){1'b0}}, 1'b1};
    wire  [CNT_W-1:0] last;      // Final count of the period
    wire              at_last;   // Period ends this cycle

    // Period is 8 times two to the select
    assign last    = (one << (BASE_LOG2 + sel)) - one;
    assign at_last = (cnt >= last);

    // Counter stops while frozen
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt <= '0;
        end else if (!freeze) begin
            cnt <= at_last ? '0 : cnt + one;
        end
    end

    // Registered period pulse
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick <= 1'b0;
        end else begin
            tick <= at_last && !freeze;
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    AST_DIV_FREEZE: assert property (
        freeze |=> !tick) else $error("sample tick while frozen");

    AST_DIV_SPACING: assert property (
        tick && !freeze ##1 (sel == '0 && !freeze) [*7] |=> tick)
        else $error("select zero period is not 8");

endmodule

// ---- tb/stl_coil_model.sv ----
`timescale 1ns/10ps

// Far side: coil bridges and converter front end
module stl_coil_model (
    // Clock
    input  wire logic hclk,
    // Converter control from the block
    input  wire logic converter_power_up,
    input  wire logic converter_reset,
    // Back EMF sign commanded by the bench
    input  wire logic emf_up,
    // Converter bit stream
    output logic      converter_sample
);
    logic toggle = 1'b0; // Chatter when converter is dead

    // Dead converter gives no stable level
    always_ff @(posedge hclk) begin
        toggle <= ~toggle;
    end

    // Live converter follows the flux sign
    assign converter_sample = (converter_power_up && !converter_reset)
                            ? emf_up : toggle;
endmodule

// ---- tb/test_stall_detector_ctrl_flags.sv ----
`timescale 1ns/10ps

module test_stall_detector_ctrl_flags;
    // Bus side
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    // Neighbour inputs
    logic        wait_mode, integrate_mode, uf_en, ov_en, count_step;
    logic [15:0] modulus_count;
    logic        converter_sample, emf_up;
    // Block outputs
    logic        coil_en, recirc, pwr_up, conv_rst, run, tick, uf_irq, ov_irq;
    logic [7:0]  acc;
    int          num_errors, n_checks;

    // Narrow accumulator keeps saturation reachable
    stl_ctrl #(.ACC_W(8)) stl_ctrl_inst (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .wait_mode(wait_mode),
        .integrate_mode(integrate_mode), .underflow_irq_enable(uf_en),
        .accum_overflow_irq_enable(ov_en), .count_step(count_step),
        .modulus_count(modulus_count), .converter_sample(converter_sample),
        .coil_control_enable(coil_en), .coil_recirculate(recirc),
        .converter_power_up(pwr_up), .converter_reset(conv_rst),
        .prescaler_run(run), .sample_tick(tick), .accumulator(acc),
        .underflow_irq(uf_irq), .accum_overflow_irq(ov_irq));

    // Motor and converter stand-in
    stl_coil_model stl_coil_model_inst (
        .hclk(hclk), .converter_power_up(pwr_up),
        .converter_reset(conv_rst), .emf_up(emf_up),
        .converter_sample(converter_sample));

    // Verdict and end of run
    task automatic stop_test();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // One comparison
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    endtask

    // Bounded wait ran out
    task automatic guard(input int k, input int lim);
        if (k >= lim) begin
            num_errors++;
            $display("unexpected timeout: expected below %0d, seen %0d",
                     lim, k);
            stop_test();
        end
    endtask

    // Clock edges
    task automatic cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask

    // Single word transfer, entered just after an edge
    task automatic bus(input logic wr, input logic [31:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        int k;
        k = 0;
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        hsize  <= 3'h2;
        do begin
            @(posedge hclk);
            k++;
        end while (hreadyout !== 1'b1 && k < 20);
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwdata <= wd;
        do begin
            @(posedge hclk);
            k++;
        end while (hreadyout !== 1'b1 && k < 40);
        rd = hrdata;
        guard(k, 40);
        chk("hresp", 32'h0, 32'(hresp));
    endtask

    // Register write
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask

    // Register read and compare
    task automatic rdchk(input string nm, input logic [31:0] a,
                         input logic [31:0] e);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        chk(nm, e, r);
    endtask

    // Edges from one sample tick to the next
    task automatic period(output int p);
        int k;
        k = 0;
        p = 0;
        do begin
            @(posedge hclk);
            k++;
        end while (tick !== 1'b1 && k < 200);
        do begin
            @(posedge hclk);
            p++;
        end while (tick !== 1'b1 && p < 200);
        guard(k, 200);
    endtask

    // Wait for the overflow request
    task automatic wait_ovf(input int lim);
        int k;
        k = 0;
        while (ov_irq !== 1'b1 && k < lim) begin
            @(posedge hclk);
            k++;
        end
        guard(k, lim);
    endtask

    // Modulus step at a given count
    task automatic step(input logic [15:0] v);
        modulus_count <= v;
        count_step    <= 1'b1;
        @(posedge hclk);
        count_step    <= 1'b0;
    endtask

    // Reset values, masks, unmapped places, coil and power bits
    task automatic t_regs();
        rdchk("ctrl reset", 32'h08, 32'h0);
        rdchk("flag reset", 32'h0c, 32'h0);
        wr(32'h08, 32'hff);
        rdchk("ctrl mask", 32'h08, 32'he3);
        wr(32'h10, 32'hff);
        rdchk("unmapped", 32'h10, 32'h0);
        wr(32'h4c, 32'h00);
        rdchk("ctrl kept", 32'h08, 32'he3);
        chk("coil enable", 32'h1, 32'(coil_en));
        chk("power up", 32'h1, 32'(pwr_up));
        wr(32'h08, 32'h03);
        cyc(2);
        chk("coil off", 32'h0, 32'(coil_en));
        chk("power down", 32'h0, 32'(pwr_up));
    endtask

    // Wait mode with and without the disable bit
    task automatic t_wait();
        wr(32'h08, 32'he0);
        wait_mode <= 1'b1;
        cyc(3);
        chk("recirculate", 32'h1, 32'(recirc));
        chk("wait power", 32'h0, 32'(pwr_up));
        chk("wait frozen", 32'h0, 32'(run));
        wr(32'h08, 32'hc0);
        cyc(2);
        chk("wait running", 32'h1, 32'(run));
        chk("wait powered", 32'h1, 32'(pwr_up));
        chk("no recirculate", 32'h0, 32'(recirc));
        wait_mode <= 1'b0;
    endtask

    // Sample periods for every select, held while integrating
    task automatic t_rate();
        int p;
        for (int s = 0; s < 4; s++) begin
            wr(32'h08, 32'(s));
            period(p);
            period(p);
            chk("tick period", 32'(8 << s), 32'(p));
        end
        integrate_mode <= 1'b1;
        wr(32'h08, 32'h40);
        period(p);
        chk("held period", 32'h40, 32'(p));
        integrate_mode <= 1'b0;
        period(p);
        period(p);
        chk("new period", 32'h8, 32'(p));
    endtask

    // Saturation both ways, flag, mask and clear
    task automatic t_accum();
        ov_en  <= 1'b1;
        emf_up <= 1'b1;
        cyc(20);
        integrate_mode <= 1'b1;
        wait_ovf(3000);
        chk("positive limit", 32'h7f, 32'(acc));
        rdchk("overflow flag", 32'h0c, 32'h01);
        ov_en <= 1'b0;
        cyc(2);
        chk("overflow masked", 32'h0, 32'(ov_irq));
        ov_en  <= 1'b1;
        emf_up <= 1'b0;
        cyc(40);
        wr(32'h0c, 32'h01);
        rdchk("overflow cleared", 32'h0c, 32'h0);
        wait_ovf(3000);
        chk("negative limit", 32'h80, 32'(acc));
        rdchk("overflow again", 32'h0c, 32'h01);
        integrate_mode <= 1'b0;
        cyc(2);
        chk("accumulator idle", 32'h0, 32'(acc));
        chk("converter reset", 32'h1, 32'(conv_rst));
        wr(32'h0c, 32'h01);
    endtask

    // Underflow flag, request gating and clearing
    task automatic t_under();
        uf_en <= 1'b1;
        step(16'h0000);
        rdchk("zero load", 32'h0c, 32'h0);
        step(16'h0001);
        cyc(2);
        chk("underflow irq", 32'h1, 32'(uf_irq));
        rdchk("underflow flag", 32'h0c, 32'h80);
        wr(32'h0c, 32'h00);
        rdchk("zero write", 32'h0c, 32'h80);
        uf_en <= 1'b0;
        cyc(2);
        chk("underflow masked", 32'h0, 32'(uf_irq));
        wr(32'h0c, 32'h80);
        rdchk("underflow cleared", 32'h0c, 32'h0);
    endtask

    // Bus clock
    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end

    // Main sequence
    initial begin
        {hresetn, hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
        {wait_mode, integrate_mode, uf_en, ov_en, count_step} = '0;
        modulus_count = 16'h0;
        emf_up = 1'b0;
        num_errors = 0;
        n_checks = 0;
        cyc(16);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_regs();
        t_wait();
        t_rate();
        t_accum();
        t_under();
        stop_test();
    end
endmodule
